// *** rtl/pc_pkg.sv ***
// constants for the instruction address sequencer and pointer registers
// assumes a single core clock and a synchronous active-high reset
package pc_pkg;

  localparam int ADDR_W     = 11;
  localparam int HIGH_W     = 3;
  localparam int LOW_W      = 8;
  localparam int DATA_W     = 8;
  localparam int WORD_W     = 16;

  localparam logic [7:0] OFS_PTR_LOCATION = 8'h80;
  localparam logic [7:0] OFS_PTR_BANK     = 8'h81;
  localparam logic [7:0] OFS_LOOKUP_HIGH  = 8'h82;
  localparam logic [7:0] OFS_AUX_LOCATION = 8'h83;
  localparam logic [7:0] OFS_AUX_BANK     = 8'h84;
  localparam logic [7:0] OFS_ADDR_LOW     = 8'hCE;
  localparam logic [7:0] OFS_ADDR_HIGH    = 8'hCF;

  localparam logic [10:0] ADDR_RESET    = 11'h000;
  localparam logic [10:0] STEP_NORMAL   = 11'h001;
  localparam logic [10:0] STEP_SKIP     = 11'h002;
  localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;
  localparam logic [7:0]  BYTE_ONE      = 8'h01;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam int          NUM_PTR_REGS  = 5;

  // operation presented by the decoder for the current instruction
  typedef enum logic [3:0] {
    op_none                 = 4'h0,
    jump_op                 = 4'h1,
    compare_skip_op         = 4'h2,
    inc_acc_skip_op         = 4'h3,
    inc_mem_skip_op         = 4'h4,
    dec_acc_skip_op         = 4'h5,
    dec_mem_skip_op         = 4'h6,
    bit_clear_skip_op       = 4'h7,
    bit_set_skip_op         = 4'h8,
    bank0_bit_clear_skip_op = 4'h9,
    bank0_bit_set_skip_op   = 4'hA,
    rom_lookup_op           = 4'hB,
    add_to_low_op           = 4'hC,
    adc_to_low_op           = 4'hD,
    bank0_add_op            = 4'hE,
    sub_to_low_op           = 4'hF
  } op_t;

  // sequencer phase: hold during reset, then run
  typedef enum logic [0:0] {
    seq_halt = 1'b0,
    seq_run  = 1'b1
  } seq_t;

endpackage

// *** rtl/skip_eval.sv ***
// evaluates the skip condition of the conditional-skip instructions
// assumes operands come from the alu path in the same cycle
`timescale 1ns/1ns
`default_nettype none
module skip_eval
  import pc_pkg::*;
(
  input  wire op_t        op,
  input  wire logic [7:0] accumulator,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] dest_old,
  input  wire logic       tested_bit,
  output logic            skip
);

  always_comb
  begin
    unique case (op)
      compare_skip_op:
        skip = (accumulator == operand);                        // see [R7]
      inc_acc_skip_op, inc_mem_skip_op:
        skip = (dest_old == BYTE_ALL_ONES);                     // see [R8]
      dec_acc_skip_op, dec_mem_skip_op:
        skip = (dest_old == BYTE_ONE);                          // see [R9]
      bit_clear_skip_op, bank0_bit_clear_skip_op:
        skip = (tested_bit == 1'b0);                            // see [R6]
      bit_set_skip_op, bank0_bit_set_skip_op:
        skip = (tested_bit == 1'b1);                            // see [R6]
      default:
        skip = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// *** rtl/ptr_regfile.sv ***
// the five working and pointer bytes, written and read by offset
// assumes one write per cycle; no reset, contents start undefined
`timescale 1ns/1ns
`default_nettype none
module ptr_regfile
  import pc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       lookup_wr,
  input  wire logic [7:0] lookup_data,
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data,
  output logic [7:0]      ptr_location,
  output logic [7:0]      ptr_bank,
  output logic [7:0]      aux_location,
  output logic [7:0]      aux_bank
);

  logic [7:0] regs [NUM_PTR_REGS];
  localparam logic [7:0] OFS_TABLE [NUM_PTR_REGS] = '{
    OFS_PTR_LOCATION, OFS_PTR_BANK, OFS_LOOKUP_HIGH, OFS_AUX_LOCATION, OFS_AUX_BANK};

  // no reset term: general bytes keep whatever they power up with
  genvar g;
  generate
    for (g = 0; g < NUM_PTR_REGS; g++)
    begin : g_reg
      always_ff @(posedge mclk)
      begin
        if (lookup_wr && OFS_TABLE[g] == OFS_LOOKUP_HIGH)
          regs[g] <= lookup_data;                               // see [R16]
        else if (wr_en && wr_addr == OFS_TABLE[g])
          regs[g] <= wr_data;                                   // see [R17]
      end
    end
  endgenerate

  // plain select; the top registers the byte together with the counter parts
  always_comb
  begin
    rd_data = BYTE_ZERO;
    for (int i = 0; i < NUM_PTR_REGS; i++)
      if (rd_addr == OFS_TABLE[i])
        rd_data = regs[i];
  end

  assign ptr_location = regs[0];                                // see [R13]
  assign ptr_bank     = regs[1];
  assign aux_location = regs[3];                                // see [R14]
  assign aux_bank     = regs[4];

endmodule
`default_nettype wire

// *** rtl/program_counter_and_pointers.sv ***
// instruction address sequencer with working and pointer registers
// assumes the decoder presents one operation per instruction on exec_en
//
// How it works
// [R1] 11-bit address: 3-bit high, 8-bit low part
// [R2] advance by one per executed instruction
// [R3] jump or call loads all eleven bits
// [R4] reset halts and clears address to zero
// [R5] true skip condition adds two
// [R6] bit test true when bit matches tested value
// [R7] compare skips when accumulator equals operand
// [R8] increment skips on wrap from FF to 00
// [R9] decrement skips on step from 01 to 00
// [R10] add into low byte carries into high
// [R11] subtract borrow leaves high part unchanged
// [R12] plain move into low keeps high part
// [R13] location/bank pair forms first indirect pointer
// [R14] auxiliary pair forms second indirect pointer
// [R15] auxiliary pair addresses rom lookup
// [R16] lookup: high byte to register, low to accumulator
// [R17] pointer bytes are not cleared by reset
`timescale 1ns/1ns
`default_nettype none
module program_counter_and_pointers
  import pc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        exec_en,
  input  wire op_t         op,
  input  wire logic [10:0] jump_target,
  input  wire logic [7:0]  accumulator,
  input  wire logic [7:0]  operand,
  input  wire logic [7:0]  dest_old,
  input  wire logic        tested_bit,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_addr,
  input  wire logic [7:0]  reg_wr_data,
  input  wire logic [7:0]  reg_rd_addr,
  input  wire logic [15:0] rom_word,
  output logic [10:0]      instr_addr,
  output logic [7:0]       reg_rd_data,
  output logic [15:0]      indirect_port_a,
  output logic [15:0]      indirect_port_b,
  output logic [10:0]      rom_lookup_addr,
  output logic             acc_load,
  output logic [7:0]       acc_load_data,
  output logic             running
);

  seq_t        seq_state;
  logic [2:0]  instr_addr_high;
  logic [7:0]  instr_addr_low;
  logic [10:0] next_instr_addr;
  logic        skip;
  logic        to_low;
  logic        lookup_now;
  logic [7:0]  pf_rd_data;
  logic [7:0]  ptr_location;
  logic [7:0]  ptr_bank;
  logic [7:0]  aux_location;
  logic [7:0]  aux_bank;

  // address as two separately written parts
  assign instr_addr_high = instr_addr[10:8];                    // see [R1]
  assign instr_addr_low  = instr_addr[7:0];

  skip_eval u_skip (
    .op          (op),
    .accumulator (accumulator),
    .operand     (operand),
    .dest_old    (dest_old),
    .tested_bit  (tested_bit),
    .skip        (skip)
  );

  assign lookup_now = exec_en && seq_state == seq_run && op == rom_lookup_op;

  ptr_regfile u_regs (
    .mclk         (mclk),
    .wr_en        (reg_wr_en),
    .wr_addr      (reg_wr_addr),
    .wr_data      (reg_wr_data),
    .lookup_wr    (lookup_now),
    .lookup_data  (rom_word[15:8]),
    .rd_addr      (reg_rd_addr),
    .rd_data      (pf_rd_data),
    .ptr_location (ptr_location),
    .ptr_bank     (ptr_bank),
    .aux_location (aux_location),
    .aux_bank     (aux_bank)
  );

  // a write of the low or high part by an instruction targets the counter
  assign to_low = reg_wr_en && reg_wr_addr == OFS_ADDR_LOW;

  always_comb
  begin
    next_instr_addr = instr_addr + STEP_NORMAL;                 // see [R2]
    if (op == jump_op)
      next_instr_addr = jump_target;                            // see [R3]
    else if (skip)
      next_instr_addr = instr_addr + STEP_SKIP;                 // see [R5]
    else if (to_low)
    begin
      unique case (op)
        add_to_low_op, adc_to_low_op, bank0_add_op:
          next_instr_addr = {instr_addr_high + {2'b00, alu_carry},
                             alu_result};                       // see [R10]
        sub_to_low_op:
          next_instr_addr = {instr_addr_high, alu_result};      // see [R11]
        default:
          next_instr_addr = {instr_addr_high, reg_wr_data};     // see [R12]
      endcase
    end
    else if (reg_wr_en && reg_wr_addr == OFS_ADDR_HIGH)
      next_instr_addr = {reg_wr_data[2:0], instr_addr_low};
  end

  // sequencer phase
  always_ff @(posedge mclk)
  begin
    if (reset)
      seq_state <= seq_halt;                                    // see [R4]
    else
      seq_state <= seq_run;
  end

  // instruction address
  always_ff @(posedge mclk)
  begin
    if (reset)
      instr_addr <= ADDR_RESET;                                 // see [R4]
    else if (seq_state == seq_run && exec_en)
      instr_addr <= next_instr_addr;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      running <= 1'b0;
    else
      running <= (seq_state == seq_run);
  end

  // register readback, counter parts and pointer bytes
  always_ff @(posedge mclk)
  begin
    if (reg_rd_addr == OFS_ADDR_LOW)
      reg_rd_data <= instr_addr_low;
    else if (reg_rd_addr == OFS_ADDR_HIGH)
      reg_rd_data <= {5'b00000, instr_addr_high};
    else
      reg_rd_data <= pf_rd_data;                                // see [R17]
  end

  // pointer outputs
  always_ff @(posedge mclk)
  begin
    indirect_port_a <= {ptr_bank, ptr_location};                // see [R13]
    indirect_port_b <= {aux_bank, aux_location};                // see [R14]
    rom_lookup_addr <= {aux_bank[2:0], aux_location};           // see [R15]
  end

  // lookup low byte goes to the accumulator
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      acc_load      <= 1'b0;
      acc_load_data <= BYTE_ZERO;
    end
    else
    begin
      acc_load      <= lookup_now;                              // see [R16]
      acc_load_data <= rom_word[7:0];
    end
  end

endmodule
`default_nettype wire

// *** sim/pc_monitor.sv ***
// port checker for the address sequencer
// assumes it is bound into program_counter_and_pointers
`timescale 1ns/1ns
`default_nettype none
module pc_monitor
  import pc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        exec_en,
  input  wire op_t         op,
  input  wire logic [10:0] jump_target,
  input  wire logic [7:0]  accumulator,
  input  wire logic [7:0]  operand,
  input  wire logic [7:0]  dest_old,
  input  wire logic [7:0]  alu_result,
  input  wire logic        alu_carry,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wr_addr,
  input  wire logic [10:0] instr_addr,
  input  wire logic        acc_load,
  input  wire logic        running
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  logic go;
  assign go = running && exec_en;

  reset_clears_addr_a: assert property (disable iff (1'b0) reset |=> instr_addr == 11'h000)
    else $error("address not cleared by reset");
  step_by_one_a: assert property (go && op == op_none && !reg_wr_en |=>
    instr_addr == $past(instr_addr) + 11'h001) else $error("address did not step by one");
  jump_load_a: assert property (go && op == jump_op |=> instr_addr == $past(jump_target))
    else $error("jump target not loaded");
  compare_skip_a: assert property (go && op == compare_skip_op && accumulator == operand |=>
    instr_addr == $past(instr_addr) + 11'h002) else $error("compare skip missed");
  inc_wrap_skip_a: assert property (go && op inside {inc_acc_skip_op, inc_mem_skip_op} &&
    dest_old == 8'hFF |=> instr_addr == $past(instr_addr) + 11'h002) else $error("inc skip missed");
  dec_zero_skip_a: assert property (go && op inside {dec_acc_skip_op, dec_mem_skip_op} &&
    dest_old == 8'h01 |=> instr_addr == $past(instr_addr) + 11'h002) else $error("dec skip missed");
  add_carry_high_a: assert property (go && alu_carry && reg_wr_en && reg_wr_addr == 8'hCE &&
    op inside {add_to_low_op, adc_to_low_op, bank0_add_op} |=>
    instr_addr == {$past(instr_addr[10:8]) + 3'h1, $past(alu_result)}) else $error("no carry");
  sub_keeps_high_a: assert property (go && op == sub_to_low_op && reg_wr_en && reg_wr_addr == 8'hCE |=>
    instr_addr[10:8] == $past(instr_addr[10:8])) else $error("high part moved on subtract");
  lookup_load_a: assert property (go && op == rom_lookup_op |-> ##[1:2] acc_load)
    else $error("lookup did not load accumulator");
endmodule
bind program_counter_and_pointers pc_monitor u_mon (.mclk, .reset, .exec_en, .op, .jump_target,
  .accumulator, .operand, .dest_old, .alu_result, .alu_carry, .reg_wr_en, .reg_wr_addr,
  .instr_addr, .acc_load, .running);
`default_nettype wire

// *** sim/program_counter_and_pointers_tb.sv ***
// self-checking bench for the address sequencer and pointer bytes
// assumes pc_monitor is bound into the design
`timescale 1ns/1ns
`default_nettype none
module program_counter_and_pointers_tb
  import pc_pkg::*;
;
  logic        mclk, reset, exec_en, tested_bit, alu_carry, reg_wr_en, acc_load, running, t;
  op_t         op, o;
  logic [10:0] jump_target, instr_addr, rom_lookup_addr, exp;
  logic [7:0]  accumulator, operand, dest_old, alu_result, reg_wr_addr, reg_wr_data;
  logic [7:0]  reg_rd_addr, reg_rd_data, acc_load_data;
  logic [15:0] rom_word, indirect_port_a, indirect_port_b;
  int          err_count = 0, checks = 0, i;

  always #20 mclk = ~mclk;

  program_counter_and_pointers DUT (.mclk, .reset, .exec_en, .op, .jump_target, .accumulator,
    .operand, .dest_old, .tested_bit, .alu_result, .alu_carry, .reg_wr_en, .reg_wr_addr,
    .reg_wr_data, .reg_rd_addr, .rom_word, .instr_addr, .reg_rd_data, .indirect_port_a,
    .indirect_port_b, .rom_lookup_addr, .acc_load, .acc_load_data, .running);

  task automatic cmp(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one executed instruction, optional low byte write, then address check
  task automatic step(input op_t so, input logic [10:0] tg = 11'h000, input logic [7:0] r = 8'h00,
                      input logic c = 1'b0, input logic w = 1'b0, input logic [7:0] opd = 8'h00,
                      input logic [7:0] dold = 8'h00, input logic tb = 1'b0);
    @(posedge mclk);
    exec_en <= 1'b1;
    op <= so;
    jump_target <= tg;
    alu_result <= r;
    alu_carry <= c;
    reg_wr_en <= w;
    reg_wr_addr <= 8'hCE;
    reg_wr_data <= r;
    operand <= opd;
    dest_old <= dold;
    tested_bit <= tb;
    @(posedge mclk);
    exec_en <= 1'b0;
    reg_wr_en <= 1'b0;
    #1 cmp(instr_addr, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr_en <= 1'b1;
    reg_wr_addr <= a;
    reg_wr_data <= d;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge mclk);
    reg_rd_addr <= a;
    repeat (2) @(posedge mclk);
    #1 cmp(reg_rd_data, want);
  endtask

  initial
  begin
    #200000;
    err_count++;
    close_out;
  end

  initial
  begin
    {mclk, exec_en, tested_bit, alu_carry, reg_wr_en} = 5'h00;
    reset = 1'b1;
    op = op_none;
    {jump_target, exp} = 22'h000000;
    {operand, dest_old, alu_result, reg_wr_addr, reg_wr_data} = 40'h00;
    accumulator = 8'h5A;
    reg_rd_addr = 8'hCE;
    rom_word = 16'hBEEF;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 cmp(instr_addr, 16'h0000);
    cmp(running, 16'h0001);
    for (i = 0; i < 3; i++)
    begin
      exp = exp + 11'h001;
      step(op_none);
    end
    exp = 11'h7FF;
    step(jump_op, 11'h7FF);
    exp = 11'h000;
    step(op_none);
    for (i = 0; i < 18; i++)
    begin
      o = op_t'(4'(i / 2 + 2));
      t = i[0];
      exp = exp + (t ? 11'h002 : 11'h001);
      step(o, 0, 0, 0, 0, t ? 8'h5A : 8'h5B, (o inside {inc_acc_skip_op, inc_mem_skip_op}) ?
        (t ? 8'hFF : 8'hFE) : (t ? 8'h01 : 8'h02),
        (o inside {bit_set_skip_op, bank0_bit_set_skip_op}) ? t : !t);
    end
    exp = 11'h323;
    step(jump_op, 11'h323);
    for (i = 0; i < 3; i++)
    begin
      exp = {exp[10:8] + 3'h1, 8'h10};
      step(op_t'(4'(i + 12)), 0, 8'h10, 1'b1, 1'b1);
    end
    exp = {exp[10:8], 8'hF0};
    step(sub_to_low_op, 0, 8'hF0, 1'b1, 1'b1);
    exp = {exp[10:8], 8'h28};
    step(op_none, 0, 8'h28, 1'b0, 1'b1);
    wr(8'h80, 8'h34);
    wr(8'h81, 8'h12);
    wr(8'h83, 8'hCD);
    wr(8'h84, 8'hAB);
    rd(8'hCF, {5'h00, exp[10:8]});
    rd(8'hCE, exp[7:0]);
    rd(8'h80, 8'h34);
    rd(8'h84, 8'hAB);
    cmp(indirect_port_a, 16'h1234);
    cmp(indirect_port_b, 16'hABCD);
    cmp(rom_lookup_addr, 16'h03CD);
    exp = exp + 11'h001;
    step(rom_lookup_op);
    for (i = 0; i < 2 && acc_load !== 1'b1; i++)
      @(posedge mclk) #1;
    cmp(acc_load, 16'h0001);
    cmp(acc_load_data, 16'h00EF);
    rd(8'h82, 8'hBE);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1 cmp(instr_addr, 16'h0000);
    cmp(indirect_port_a, 16'h1234);
    close_out;
  end
endmodule
`default_nettype wire
